// ==== rtl/i2c_slave_pkg.sv ====
// Constants and types shared by the register-bank I2C slave
package i2c_slave_pkg;

	// Seven-bit own address with the two strap bits in the low positions
	localparam logic [6:0] OWN_ADDR_BASE = 7'h58;
	localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
	localparam logic [7:0] GC_CODE_RESET = 8'h06;
	localparam logic [7:0] GC_CODE_LATCH = 8'h04;
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
	// Upper two bits of the ten-bit form of the own address
	localparam logic [1:0] TEN_BIT_HIGH = 2'h0;

	// Bit positions and counts within a byte frame
	localparam logic [3:0] BIT_LAST_DATA = 4'h7;
	localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
	localparam logic [3:0] BIT_CNT_RST = 4'h0;

	// Values after reset
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [1:0] STRAP_RST = 2'h0;

	// Bus rates the front end is built for, in kbit/s, and the core clock
	localparam int STD_RATE_KBPS = 100;
	localparam int FAST_RATE_KBPS = 400;
	localparam int CORE_CLK_MHZ = 200;
	// Core cycles in the shortest bus bit; must leave room for sync delay
	localparam int CYC_PER_FAST_BIT = (CORE_CLK_MHZ * 1000) / FAST_RATE_KBPS;

	// Protocol engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEV = 3'b001,
		ST_DEV_LOW = 3'b010,
		ST_PTR = 3'b011,
		ST_WDATA = 3'b100,
		ST_RACK = 3'b101,
		ST_RDATA = 3'b110,
		ST_GCALL = 3'b111
	} slave_state_e;

	// One register write towards the bank
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} reg_wr_s;

endpackage : i2c_slave_pkg

// ==== rtl/i2c_register_slave.sv ====
// I2C slave front end giving byte access to an 8-bit addressed register bank
`timescale 1ns/10ps
`default_nettype none

module i2c_register_slave
	import i2c_slave_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic strap_hi,
	input wire logic strap_lo,
	output logic wr_valid,
	output reg_wr_s wr,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data,
	output logic soft_rst
);

	// Link domain: bit sampler on the master's clock
	logic link_bit_r;
	logic link_tog_r;

	// Core domain registers
	logic scl_s1_r, scl_s2_r, scl_d_r;
	logic sda_s1_r, sda_s2_r, sda_d_r;
	logic tog_s1_r, tog_s2_r, tog_d_r;
	logic bit_s1_r, bit_s2_r;
	logic evt_d_r;
	logic [1:0] strap_s1_r, strap_s2_r;
	logic [1:0] strap_sel_r;
	logic latch_pend_r;
	slave_state_e state_r, state_nxt;
	logic [3:0] cnt_r;
	logic [7:0] shift_r;
	logic [7:0] ptr_r;
	logic [7:0] tx_r;
	logic ack_r;
	logic ten_sel_r;
	logic sda_oe_r;
	logic wr_valid_r;
	reg_wr_s wr_r;
	logic soft_rst_r;

	always_ff @(posedge scl) begin
		if (!rst_b) begin
			link_bit_r <= 1'b0;
			link_tog_r <= 1'b0;
		end else begin
			link_bit_r <= sda_in;
			link_tog_r <= ~link_tog_r;
		end
	end

	// Two-stage synchronisers for pins and the link toggle
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			tog_s1_r <= 1'b0;
			tog_s2_r <= 1'b0;
			bit_s1_r <= 1'b0;
			bit_s2_r <= 1'b0;
			strap_s1_r <= STRAP_RST;
			strap_s2_r <= STRAP_RST;
		end else begin
			scl_s1_r <= scl;
			scl_s2_r <= scl_s1_r;
			sda_s1_r <= sda_in;
			sda_s2_r <= sda_s1_r;
			tog_s1_r <= link_tog_r;
			tog_s2_r <= tog_s1_r;
			bit_s1_r <= link_bit_r;
			bit_s2_r <= bit_s1_r;
			strap_s1_r <= {strap_hi, strap_lo};
			strap_s2_r <= strap_s1_r;
		end
	end

	// Delayed copies for edge detection
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			tog_d_r <= 1'b0;
			evt_d_r <= 1'b0;
		end else begin
			scl_d_r <= scl_s2_r;
			sda_d_r <= sda_s2_r;
			tog_d_r <= tog_s2_r;
			evt_d_r <= tog_s2_r ^ tog_d_r;
		end
	end

	// Bus conditions and bit events
	// start detect
	wire start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	wire stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
	wire scl_fall = scl_d_r & ~scl_s2_r;
	// Bit value is read one cycle after its toggle so both have settled
	wire bit_evt = evt_d_r;
	wire bit_val = bit_s2_r;
	wire byte_done = bit_evt & (cnt_r == BIT_LAST_DATA);
	wire ack_slot = bit_evt & (cnt_r == BIT_ACK_SLOT);
	wire [7:0] byte_in = {shift_r[6:0], bit_val};

	// Address decode of the completed byte
	// strap address
	wire [6:0] own_addr = {OWN_ADDR_BASE[6:2], strap_sel_r};
	wire hit_seven = (byte_in[7:1] == own_addr);
	wire hit_ten_hi = (byte_in[7:3] == TEN_BIT_PREFIX) & (byte_in[2:1] == TEN_BIT_HIGH);
	wire hit_ten_lo = (byte_in == {1'b0, own_addr});
	wire hit_gcall = (byte_in == GC_ADDR_BYTE);
	wire gc_reset = (byte_in == GC_CODE_RESET);
	wire gc_latch = (byte_in == GC_CODE_LATCH);
	wire tx_bit = tx_r[3'h7 - cnt_r[2:0]];

	// Next state when a byte completes or an acknowledge slot passes
	always_comb begin
		state_nxt = state_r;
		if (byte_done) begin
			unique case (state_r)
				ST_DEV: begin
					if (hit_gcall)
						state_nxt = ST_GCALL;
					else if (hit_seven)
						state_nxt = byte_in[0] ? ST_RACK : ST_PTR;
					else if (hit_ten_hi & ~byte_in[0])
						state_nxt = ST_DEV_LOW;
					else if (hit_ten_hi & ten_sel_r)
						state_nxt = ST_RACK;
					else
						state_nxt = ST_IDLE;
				end
				ST_DEV_LOW: state_nxt = hit_ten_lo ? ST_PTR : ST_IDLE;
				ST_PTR: state_nxt = ST_WDATA;
				ST_GCALL: state_nxt = ST_IDLE;
				ST_IDLE, ST_WDATA, ST_RACK, ST_RDATA: state_nxt = state_r;
			endcase
		end else if (ack_slot) begin
			unique case (state_r)
				ST_RACK: state_nxt = ST_RDATA;
				ST_RDATA: state_nxt = bit_val ? ST_IDLE : ST_RDATA;
				ST_IDLE, ST_DEV, ST_DEV_LOW, ST_PTR, ST_WDATA, ST_GCALL:
					state_nxt = state_r;
			endcase
		end
	end

	// Engine state; start and stop take priority over bit traffic
	always_ff @(posedge clock) begin
		if (!rst_b)
			state_r <= ST_IDLE;
		else if (start_det)
			state_r <= ST_DEV;
		else if (stop_det)
			state_r <= ST_IDLE;
		else
			state_r <= state_nxt;
	end

	// Bit counter and receive shifter
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cnt_r <= BIT_CNT_RST;
			shift_r <= 8'h00;
		end else if (start_det | stop_det) begin
			cnt_r <= BIT_CNT_RST;
		end else if (ack_slot) begin
			cnt_r <= BIT_CNT_RST;
		end else if (bit_evt) begin
			cnt_r <= cnt_r + 4'h1;
			shift_r <= byte_in;
		end
	end

	// Whether the slave acknowledges the byte just received
	// ack on match
	always_ff @(posedge clock) begin
		if (!rst_b)
			ack_r <= 1'b0;
		else if (start_det)
			ack_r <= 1'b0;
		else if (byte_done) begin
			unique case (state_r)
				ST_DEV: ack_r <= hit_gcall | hit_seven | (hit_ten_hi & (~byte_in[0] | ten_sel_r));
				ST_DEV_LOW: ack_r <= hit_ten_lo;
				ST_PTR, ST_WDATA: ack_r <= 1'b1;
				ST_GCALL: ack_r <= gc_reset | gc_latch;
				ST_IDLE, ST_RACK, ST_RDATA: ack_r <= 1'b0;
			endcase
		end
	end

	// Ten-bit selection survives a repeated start, cleared by stop
	always_ff @(posedge clock) begin
		if (!rst_b)
			ten_sel_r <= 1'b0;
		else if (stop_det | soft_rst_r)
			ten_sel_r <= 1'b0;
		else if (byte_done & (state_r == ST_DEV) & hit_seven)
			ten_sel_r <= 1'b0;
		else if (byte_done & (state_r == ST_DEV_LOW) & hit_ten_lo)
			ten_sel_r <= 1'b1;
	end

	// Register pointer; 8-bit arithmetic wraps 0xff to 0x00
	// 8-bit pointer
	always_ff @(posedge clock) begin
		if (!rst_b | soft_rst_r)
			ptr_r <= PTR_RST;
		else if (byte_done & (state_r == ST_PTR))
			ptr_r <= byte_in;
		else if (byte_done & (state_r == ST_WDATA))
			ptr_r <= ptr_r + 8'h01;
		else if (byte_done & (state_r == ST_RDATA))
			ptr_r <= ptr_r + 8'h01;
	end

	// Transmit byte loaded at the ack slot that precedes each read byte
	// read data
	always_ff @(posedge clock) begin
		if (!rst_b)
			tx_r <= 8'h00;
		else if (ack_slot & ((state_r == ST_RACK) | ((state_r == ST_RDATA) & ~bit_val)))
			tx_r <= rd_data;
	end

	// Write strobe towards the bank, one cycle per data byte
	// writes only in data phase
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wr_valid_r <= 1'b0;
			wr_r <= '0;
		end else begin
			wr_valid_r <= byte_done & (state_r == ST_WDATA) & ~start_det & ~stop_det;
			if (byte_done & (state_r == ST_WDATA))
				wr_r <= '{addr: ptr_r, data: byte_in};
		end
	end

	// SDA drive, set only after a falling SCL; start and stop release it
	// ack and release
	always_ff @(posedge clock) begin
		if (!rst_b)
			sda_oe_r <= 1'b0;
		else if (start_det | stop_det)
			sda_oe_r <= 1'b0;
		else if (scl_fall) begin
			if (cnt_r == BIT_ACK_SLOT)
				sda_oe_r <= ack_r & (state_r != ST_RDATA);
			else if (state_r == ST_RDATA)
				sda_oe_r <= ~tx_bit;
			else
				sda_oe_r <= 1'b0;
		end
	end

	// General call actions and strap latching; first latch after reset release loads STRAP_RST, not the pins
	// strap latch
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			latch_pend_r <= 1'b1;
			strap_sel_r <= STRAP_RST;
			soft_rst_r <= 1'b0;
		end else begin
			latch_pend_r <= 1'b0;
			soft_rst_r <= byte_done & (state_r == ST_GCALL) & gc_reset;
			if (latch_pend_r | (byte_done & (state_r == ST_GCALL) & (gc_reset | gc_latch)))
				strap_sel_r <= strap_s2_r;
		end
	end

	// Outputs
	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_r;
	assign wr_valid = wr_valid_r;
	assign wr = wr_r;
	assign rd_addr = ptr_r;
	assign soft_rst = soft_rst_r;

endmodule : i2c_register_slave

`default_nettype wire

// ==== tb/i2c_register_slave_chk.sv ====
// Port checker for the register slave, bound to its top module
`timescale 1ns/10ps
`default_nettype none

module i2c_register_slave_chk
	import i2c_slave_pkg::*;
(
	input wire logic clock,
	input wire logic rst_b,
	input wire logic scl,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic strap_hi,
	input wire logic strap_lo,
	input wire logic wr_valid,
	input wire reg_wr_s wr,
	input wire logic [7:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic soft_rst
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	// Quiet outputs and cleared pointer as reset lifts
	a_reset_quiet: assert property (
		$rose(rst_b) |-> !wr_valid && !sda_oe && !soft_rst && rd_addr == PTR_RST)
		else $error("outputs busy at reset release");
	// Pin only ever pulls low
	a_open_drain: assert property (
		sda_out == 1'b0) else $error("data pin driven high");
	// Strobe lasts one cycle, then stays low for the next 8 cycles
	a_wr_pulse: assert property (
		wr_valid |=> !wr_valid [*8]) else $error("write strobe too long");
	a_wr_hold: assert property (
		$changed(wr) |-> wr_valid) else $error("write payload moved without strobe");
	// Pointer steps with wrap after each stored byte
	a_ptr_step: assert property (
		wr_valid |-> ##[0:2] rd_addr == wr.addr + 8'h01) else $error("pointer did not step");
	// Stored byte is acknowledged
	a_wr_ack: assert property (
		wr_valid |-> ##[0:16] sda_oe) else $error("stored byte not acknowledged");
	// Slave starts driving the line only while the clock is low
	a_oe_rise_low: assert property (
		$rose(sda_oe) |-> !scl && $past(!scl, 2)) else $error("data driven with clock high");
	// Soft reset clears the pointer
	a_soft_ptr: assert property (
		soft_rst |-> ##[0:2] rd_addr == PTR_RST) else $error("pointer kept on soft reset");
endmodule : i2c_register_slave_chk

bind i2c_register_slave i2c_register_slave_chk i2c_register_slave_chk_i (.clock, .rst_b,
	.scl, .sda_in, .sda_out, .sda_oe, .strap_hi, .strap_lo, .wr_valid, .wr, .rd_addr,
	.rd_data, .soft_rst);

`default_nettype wire

// ==== tb/host_model.sv ====
// Host bus master model driving the serial clock and data lines
`timescale 1ns/10ps
`default_nettype none

module host_model (
	output logic scl,
	output logic sda_drv,
	input wire logic sda_w
);
	// Bus idles released with the clock high
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// One clock pulse with data released, so the link sampler clears under reset
	task automatic reset_pulse();
		#5 scl = 1'b0;
		#20 scl = 1'b1;
	endtask : reset_pulse

	// Data changes only while the clock is low
	task automatic bit_io(input logic b, output logic s);
		#8 sda_drv = b;
		#36 scl = 1'b1;
		#10 s = sda_w;
		#10 scl = 1'b0;
	endtask : bit_io

	// Start when a is high, stop when low, data moving with clock high
	task automatic cond(input logic a);
		#8 sda_drv = a;
		#36 scl = 1'b1;
		#20 sda_drv = ~a;
		#20 scl = ~a;
		#80;
	endtask : cond

	// Eight bits MSB first, then the ninth bit answers
	task automatic xfer(input logic [7:0] o, input logic n9, output logic [7:0] i,
		output logic s9);
		for (int k = 7; k >= 0; k--) bit_io(o[k], i[k]);
		bit_io(n9, s9);
	endtask : xfer
endmodule : host_model

`default_nettype wire

// ==== tb/i2c_register_slave_tb.sv ====
// Self-checking bench for the register slave with a host master model
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("mismatch %s exp %0h got %0h", nm, e, g); \
	end \
end

module i2c_register_slave_tb;
	import i2c_slave_pkg::*;
	logic clock, rst_b, strap_hi, strap_lo, scl, sda_drv, sda_out, sda_oe, wr_valid, soft_rst, s;
	reg_wr_s wr;
	logic [7:0] rd_addr, rd_data, d;
	logic [7:0] mem [256];
	reg_wr_s wq [$];
	int n_fail = 0, tests_run = 0, cyc = 0, n_srst = 0;
	wire logic sda_w;
	// Open-drain wire with pull-up; bank answers combinationally
	assign sda_w = sda_drv & (sda_out | ~sda_oe);
	assign rd_data = mem[rd_addr];
	i2c_register_slave i2c_register_slave_i (.clock, .rst_b, .scl, .sda_in(sda_w), .sda_out,
		.sda_oe, .strap_hi, .strap_lo, .wr_valid, .wr, .rd_addr, .rd_data, .soft_rst);
	host_model host_model_i (.scl, .sda_drv, .sda_w);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Bank model: applies strobed writes, logs them, counts soft resets
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (wr_valid === 1'b1) begin
			mem[wr.addr] <= wr.data;
			wq.push_back(wr);
		end
		if (soft_rst === 1'b1) n_srst <= n_srst + 1;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim
	task automatic st();
		host_model_i.cond(1'b1);
	endtask : st
	task automatic sp();
		host_model_i.cond(1'b0);
	endtask : sp
	// Sends a byte and compares the answer bit
	task automatic wb(input logic [7:0] b, input logic e);
		host_model_i.xfer(b, 1'b1, d, s);
		`CHK("ack", e, ~s)
	endtask : wb
	// Reads a byte, acking when more follows
	task automatic rd(input logic more, input logic [7:0] e);
		host_model_i.xfer(8'hff, ~more, d, s);
		`CHK("rd data", e, d)
	endtask : rd

	// Write across the top of the map, then bytes with no start
	task automatic t_write();
		st();
		wb(8'hb0, 1'b1);
		wb(8'hfe, 1'b1);
		wb(8'h11, 1'b1);
		wb(8'h22, 1'b1);
		wb(8'h33, 1'b1);
		sp();
		wb(8'hb0, 1'b0);
		wb(8'h55, 1'b0);
		sp();
		`CHK("writes", 3, wq.size())
		for (int i = 0; i < 3; i++) begin
			`CHK("wr addr", 8'(8'hfe + i), wq[i].addr)
			`CHK("wr data", 8'(8'h11 * (i + 1)), wq[i].data)
		end
		$display("done write");
	endtask : t_write

	// Sequential read over the wrap, then reading past a nack
	task automatic t_read();
		st();
		wb(8'hb0, 1'b1);
		wb(8'hff, 1'b1);
		st();
		wb(8'hb1, 1'b1);
		rd(1'b1, 8'h22);
		rd(1'b1, 8'h33);
		rd(1'b0, 8'h5b);
		rd(1'b0, 8'hff);
		sp();
		`CHK("oe idle", 1'b0, sda_oe)
		$display("done read");
	endtask : t_read

	// Foreign and other-strap addresses are ignored
	task automatic t_nomatch();
		st();
		wb(8'hb8, 1'b0);
		wb(8'h05, 1'b0);
		wb(8'h77, 1'b0);
		st();
		wb(8'hb2, 1'b0);
		sp();
		`CHK("writes", 3, wq.size())
		$display("done nomatch");
	endtask : t_nomatch

	// Ten-bit write, then ten-bit read after restart
	task automatic t_ten();
		st();
		wb({TEN_BIT_PREFIX, TEN_BIT_HIGH, 1'b0}, 1'b1);
		wb({1'b0, OWN_ADDR_BASE}, 1'b1);
		wb(8'h40, 1'b1);
		wb(8'hc3, 1'b1);
		st();
		wb({TEN_BIT_PREFIX, TEN_BIT_HIGH, 1'b1}, 1'b1);
		rd(1'b0, 8'h1b);
		sp();
		`CHK("ten wr", 16'h40c3, wq[3])
		$display("done ten");
	endtask : t_ten

	// Latch, soft reset and unknown codes of the general call
	task automatic t_gcall();
		@(posedge clock);
		#1 {strap_hi, strap_lo} = 2'b11;
		st();
		wb(8'hb6, 1'b0);
		st();
		wb(GC_ADDR_BYTE, 1'b1);
		wb(GC_CODE_LATCH, 1'b1);
		sp();
		#2000;
		st();
		wb(8'hb6, 1'b1);
		wb(8'h20, 1'b1);
		sp();
		`CHK("soft resets", 0, n_srst)
		@(posedge clock);
		#1 {strap_hi, strap_lo} = 2'b01;
		st();
		wb(GC_ADDR_BYTE, 1'b1);
		wb(GC_CODE_RESET, 1'b1);
		sp();
		#2000;
		`CHK("soft resets", 1, n_srst)
		`CHK("ptr", PTR_RST, rd_addr)
		st();
		wb(8'hb3, 1'b1);
		rd(1'b0, 8'h33);
		st();
		wb(GC_ADDR_BYTE, 1'b1);
		wb(8'h33, 1'b0);
		sp();
		`CHK("soft resets", 1, n_srst)
		$display("done gcall");
	endtask : t_gcall

	initial begin
		rst_b = 1'b0;
		strap_hi = 1'b0;
		strap_lo = 1'b0;
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
		// The link sampler only resets on a bus clock edge
		fork
			host_model_i.reset_pulse();
		join_none
		repeat (10) @(posedge clock);
		#1 rst_b = 1'b1;
		repeat (8) @(posedge clock);
		`CHK("ptr", PTR_RST, rd_addr)
		t_write();
		t_read();
		t_nomatch();
		t_ten();
		t_gcall();
		end_sim();
	end
	// Cuts a hang short
	initial begin
		wait (cyc == 30000);
		n_fail++;
		end_sim();
	end
endmodule : i2c_register_slave_tb

`default_nettype wire
